// ==== verilog/uai_pkg.sv ====
package uai_pkg;

    // ***********************************************************
    // register map
    // ***********************************************************
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_DIO = 8'h04;
    localparam logic [7:0] ADDR_UMI = 8'h08;
    localparam logic [7:0] ADDR_STATUS = 8'h0C;
    localparam logic [7:0] ADDR_DATA = 8'h10;
    localparam logic [7:0] ADDR_INFO = 8'h14;

    // ***********************************************************
    // field positions
    // ***********************************************************
    localparam int CTRL_QEN_LSB = 0;
    localparam int CTRL_SYSRST_BIT = 8;
    localparam int DIO_OE_LSB = 8;
    localparam int UMI_OE_LSB = 4;
    localparam int ST_CONFIG_BIT = 0;
    localparam int ST_READY_BIT = 1;
    localparam int ST_BUSY_BIT = 2;
    localparam int ST_SLOT_LSB = 4;
    localparam int ST_CARRIER_LSB = 8;
    localparam int ST_DIO_LSB = 12;
    localparam int ST_UMI_LSB = 20;
    localparam int ST_BURST_LSB = 24;
    localparam int INFO_COUNT_LSB = 8;

    // ***********************************************************
    // reset values and counts
    // ***********************************************************
    localparam logic [5:0] RST_QUEUE_EN = 6'h00;
    localparam logic [7:0] RST_DIGITAL_IO_OUTPUT = 8'h00;
    localparam logic [7:0] RST_DIO_OE_N = 8'hFF;
    localparam logic [3:0] RST_INTERCONNECT_OUTPUT = 4'h0;
    localparam logic [3:0] RST_UMI_OE_N = 4'hF;
    localparam logic RST_SYSRST_N = 1'b1;
    localparam int WAIT_LIMIT_CYCLES = 16;
    localparam int NUM_QUEUES = 6;
    localparam int WORD_W = 32;

    // ***********************************************************
    // types
    // ***********************************************************
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_REQ,
        ST_WAIT
    } uai_fsm_t;

    typedef struct packed {
        logic [NUM_QUEUES-1:0] data_valid;
        logic [NUM_QUEUES-1:0] word_available;
        logic [NUM_QUEUES-1:0] burst_possible;
    } uai_queue_flags_t;

    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } uai_reg_req_t;

endpackage

// ==== verilog/uai_user_application_entity.sv ====
`timescale 1ns/1ps
// Contract
// - The module reset is asynchronous and active high and holds all state at its reset values while high, with output enables high and reset request at one.
// - The configuration input is active low, a low level meaning configuration is asserted.
// - Each of the eight digital lines is driven only while its own active-low enable is low.
// - Each of the four interconnect lines is driven only while its own active-low enable is low.
// - The system reset request output stays at one unless the application deliberately uses it.
// - The slot identifier and carrier identifier arrive as four-bit inputs.
// - With separate FIFO clocks, input queue logic runs on the read clock the top returns.
// - With separate FIFO clocks, a write clock source is driven for the output queues.
// - With a common FIFO clock, only the shared clock source is driven and used.
// - Six input queues each give valid, word-available and burst flags plus 32-bit data.
// - Interface port names are reserved and not reused for unrelated internal signals.
module uai_user_application_entity #(
    parameter bit COMMON_FIFO_CLOCK = 1'b0,
    parameter int WAIT_LIMIT = uai_pkg::WAIT_LIMIT_CYCLES,
    parameter int COUNT_W = 24
) (
    // clock, enable, reset; port names kept as reserved interface names
    input wire logic clock_i,
    input wire logic ce_i,
    input wire logic rst_i,
    // general module inputs
    input wire logic config_n_i,
    input wire logic [3:0] slot_identifier_i,
    input wire logic [3:0] carrier_identifier_i,
    // digital io
    input wire logic [7:0] digital_io_input_i,
    output logic [7:0] digital_io_output_o,
    output logic [7:0] digital_io_output_enable_n_o,
    // interconnect
    input wire logic [3:0] interconnect_input_i,
    output logic [3:0] interconnect_output_o,
    output logic [3:0] interconnect_output_enable_n_o,
    // system reset request
    output logic system_reset_request_n_o,
    // fifo clock sources
    output logic fifo_read_clock_source_o,
    output logic fifo_write_clock_source_o,
    output logic shared_fifo_clock_source_o,
    // input queues
    input wire uai_pkg::uai_queue_flags_t in_queue_flags_i,
    input wire logic [5:0][31:0] in_queue_data_i,
    output logic [5:0] in_queue_read_request_o,
    // register port
    input wire uai_pkg::uai_reg_req_t reg_req_i,
    output logic [31:0] reg_rdata_o
);

    // ***********************************************************
    // parameter checks
    // ***********************************************************
    if (WAIT_LIMIT < 2 || WAIT_LIMIT > 255) begin : g_bad_wait
        $error("WAIT_LIMIT must lie in 2..255");
    end
    if (COUNT_W < 1 || COUNT_W > 24) begin : g_bad_count
        $error("COUNT_W must lie in 1..24");
    end

    // ***********************************************************
    // state
    // ***********************************************************
    typedef struct packed {
        uai_pkg::uai_fsm_t fsm;
        logic [5:0] queue_en;
        logic sysrst_n;
        logic [7:0] digital_io_output;
        logic [7:0] dio_oe_n;
        logic [3:0] interconnect_output;
        logic [3:0] umi_oe_n;
        logic [5:0] read_req;
        logic [2:0] cur_q;
        logic [2:0] last_q;
        logic [7:0] wait_cnt;
        logic [31:0] data;
        logic ready;
        logic [COUNT_W-1:0] count;
        logic [31:0] rdata;
        logic clk_div;
    } uai_state_t;

    uai_state_t state_ff;
    uai_state_t nxt_state;

    // round-robin pick of the next queue after the last served one
    function automatic logic [3:0] pick_queue(input logic [5:0] cand, input logic [2:0] last);
        logic [3:0] res;
        logic [2:0] idx;
        res = 4'h8;
        for (int k = 5; k >= 0; k--) begin
            idx = 3'((32'(last) + 1 + k) % 6);
            if (cand[idx]) begin
                res = {1'b0, idx};
            end
        end
        return res;
    endfunction

    function automatic logic [31:0] status_word(input uai_state_t s, input logic cfg_n,
                                                input logic [3:0] slot,
                                                input logic [3:0] carrier,
                                                input logic [7:0] dio,
                                                input logic [3:0] umi,
                                                input logic [5:0] burst);
        logic [31:0] w;
        w = 32'h0000_0000;
        w[uai_pkg::ST_CONFIG_BIT] = ~cfg_n;
        w[uai_pkg::ST_READY_BIT] = s.ready;
        w[uai_pkg::ST_BUSY_BIT] = (s.fsm != uai_pkg::ST_IDLE);
        w[uai_pkg::ST_SLOT_LSB +: 4] = slot;
        w[uai_pkg::ST_CARRIER_LSB +: 4] = carrier;
        w[uai_pkg::ST_DIO_LSB +: 8] = dio;
        w[uai_pkg::ST_UMI_LSB +: 4] = umi;
        w[uai_pkg::ST_BURST_LSB +: 6] = burst;
        return w;
    endfunction

    // ***********************************************************
    // next state
    // ***********************************************************
    always_comb begin
        logic [3:0] sel;
        logic [31:0] wd;
        sel = pick_queue(in_queue_flags_i.word_available & state_ff.queue_en, state_ff.last_q);
        wd = reg_req_i.wdata;
        nxt_state = state_ff;
        nxt_state.read_req = 6'h00;
        nxt_state.rdata = 32'h0000_0000;
        // clock source toggling on each cycle with ce_i high, for the returned fifo clock(s)
        nxt_state.clk_div = ~state_ff.clk_div;

        // register writes
        if (reg_req_i.wr) begin
            case (reg_req_i.addr)
                uai_pkg::ADDR_CTRL: begin
                    nxt_state.queue_en = wd[uai_pkg::CTRL_QEN_LSB +: 6];
                    nxt_state.sysrst_n = ~wd[uai_pkg::CTRL_SYSRST_BIT];
                end
                uai_pkg::ADDR_DIO: begin
                    nxt_state.digital_io_output = wd[7:0];
                    nxt_state.dio_oe_n = wd[uai_pkg::DIO_OE_LSB +: 8];
                end
                uai_pkg::ADDR_UMI: begin
                    nxt_state.interconnect_output = wd[3:0];
                    nxt_state.umi_oe_n = wd[uai_pkg::UMI_OE_LSB +: 4];
                end
                default: begin
                end
            endcase
        end

        // register reads, data present the next cycle only
        if (reg_req_i.rd) begin
            case (reg_req_i.addr)
                uai_pkg::ADDR_CTRL: begin
                    nxt_state.rdata[uai_pkg::CTRL_QEN_LSB +: 6] = state_ff.queue_en;
                    nxt_state.rdata[uai_pkg::CTRL_SYSRST_BIT] = ~state_ff.sysrst_n;
                end
                uai_pkg::ADDR_DIO: begin
                    nxt_state.rdata[7:0] = state_ff.digital_io_output;
                    nxt_state.rdata[uai_pkg::DIO_OE_LSB +: 8] = state_ff.dio_oe_n;
                end
                uai_pkg::ADDR_UMI: begin
                    nxt_state.rdata[3:0] = state_ff.interconnect_output;
                    nxt_state.rdata[uai_pkg::UMI_OE_LSB +: 4] = state_ff.umi_oe_n;
                end
                uai_pkg::ADDR_STATUS: begin
                    nxt_state.rdata = status_word(state_ff, config_n_i,
                                                  slot_identifier_i, carrier_identifier_i,
                                                  digital_io_input_i, interconnect_input_i,
                                                  in_queue_flags_i.burst_possible);
                end
                uai_pkg::ADDR_DATA: begin
                    nxt_state.rdata = state_ff.data;
                    nxt_state.ready = 1'b0;
                end
                uai_pkg::ADDR_INFO: begin
                    nxt_state.rdata[2:0] = state_ff.last_q;
                    nxt_state.rdata[uai_pkg::INFO_COUNT_LSB +: COUNT_W] = state_ff.count;
                end
                default: begin
                end
            endcase
        end

        // input queue reader
        case (state_ff.fsm)
            uai_pkg::ST_IDLE: begin
                // config asserted (low) holds the reader idle
                if (config_n_i && !state_ff.ready && !sel[3]) begin
                    nxt_state.cur_q = sel[2:0];
                    nxt_state.read_req[sel[2:0]] = 1'b1;
                    nxt_state.wait_cnt = 8'h00;
                    nxt_state.fsm = uai_pkg::ST_REQ;
                end
            end
            uai_pkg::ST_REQ: begin
                nxt_state.fsm = uai_pkg::ST_WAIT;
            end
            uai_pkg::ST_WAIT: begin
                if (in_queue_flags_i.data_valid[state_ff.cur_q]) begin
                    nxt_state.data = in_queue_data_i[state_ff.cur_q];
                    nxt_state.ready = 1'b1;
                    nxt_state.last_q = state_ff.cur_q;
                    nxt_state.count = state_ff.count + COUNT_W'(1);
                    nxt_state.fsm = uai_pkg::ST_IDLE;
                end else if (state_ff.wait_cnt == 8'(WAIT_LIMIT - 1)) begin
                    nxt_state.last_q = state_ff.cur_q;
                    nxt_state.fsm = uai_pkg::ST_IDLE;
                end else begin
                    nxt_state.wait_cnt = state_ff.wait_cnt + 8'h01;
                end
            end
            default: begin
                nxt_state.fsm = uai_pkg::ST_IDLE;
            end
        endcase
    end

    // ***********************************************************
    // registers
    // ***********************************************************
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            state_ff <= '0;
            state_ff.fsm <= uai_pkg::ST_IDLE;
            state_ff.queue_en <= uai_pkg::RST_QUEUE_EN;
            state_ff.sysrst_n <= uai_pkg::RST_SYSRST_N;
            state_ff.digital_io_output <= uai_pkg::RST_DIGITAL_IO_OUTPUT;
            state_ff.dio_oe_n <= uai_pkg::RST_DIO_OE_N;
            state_ff.interconnect_output <= uai_pkg::RST_INTERCONNECT_OUTPUT;
            state_ff.umi_oe_n <= uai_pkg::RST_UMI_OE_N;
        end else if (ce_i) begin
            state_ff <= nxt_state;
        end
    end

    // ***********************************************************
    // outputs
    // ***********************************************************
    assign digital_io_output_o = state_ff.digital_io_output;
    assign digital_io_output_enable_n_o = state_ff.dio_oe_n;
    assign interconnect_output_o = state_ff.interconnect_output;
    assign interconnect_output_enable_n_o = state_ff.umi_oe_n;
    assign system_reset_request_n_o = state_ff.sysrst_n;
    assign in_queue_read_request_o = state_ff.read_req;
    assign reg_rdata_o = state_ff.rdata;
    // clock_i is the returned fifo clock; unused sources are held low
    assign fifo_read_clock_source_o = COMMON_FIFO_CLOCK ? 1'b0 : state_ff.clk_div;
    assign fifo_write_clock_source_o = COMMON_FIFO_CLOCK ? 1'b0 : state_ff.clk_div;
    assign shared_fifo_clock_source_o = COMMON_FIFO_CLOCK ? state_ff.clk_div : 1'b0;

endmodule // uai_user_application_entity

// ==== verification/uai_queue_model.sv ====
`timescale 1ns/1ps
// ********************************************************
// input queue side of the top level
// ********************************************************
module uai_queue_model (
    // clock and reset
    input wire logic clock_i,
    input wire logic rst_i,
    // bench control
    input wire logic [5:0] avail_i,
    input wire logic [7:0] latency_i,
    input wire logic [31:0] word_i,
    // user side
    input wire logic [5:0] read_request_i,
    output uai_pkg::uai_queue_flags_t flags_o,
    output logic [5:0][31:0] data_o
);
    logic [7:0] cnt_ff;
    logic [2:0] q_ff;
    logic [5:0] valid_ff;
    assign flags_o = '{data_valid: valid_ff, word_available: avail_i, burst_possible: avail_i};
    // idle data lines invert every cycle so a stale word is never mistaken for a fresh one
    always @(posedge clock_i) begin
        valid_ff <= 6'h00;
        for (int i = 0; i < 6; i++) data_o[i] <= rst_i ? 32'h0 : ~data_o[i];
        if (rst_i) cnt_ff <= 8'h00;
        else if (read_request_i != 6'h00) begin
            cnt_ff <= latency_i;
            for (int i = 0; i < 6; i++) if (read_request_i[i]) q_ff <= 3'(i);
        end else if (cnt_ff == 8'h01) begin
            valid_ff[q_ff] <= 1'b1;
            data_o[q_ff] <= word_i;
            cnt_ff <= 8'h00;
        end else if (cnt_ff != 8'h00) cnt_ff <= cnt_ff - 8'h01;
    end
endmodule // uai_queue_model

// ==== verification/uai_assertions.sv ====
`timescale 1ns/1ps
module uai_assertions (
    // clock and reset
    input wire logic clock_i,
    input wire logic rst_i,
    // watched inputs
    input wire logic config_n_i,
    input wire logic [3:0] slot_identifier_i,
    input wire logic [3:0] carrier_identifier_i,
    input wire uai_pkg::uai_queue_flags_t in_queue_flags_i,
    input wire uai_pkg::uai_reg_req_t reg_req_i,
    // watched outputs
    input wire logic [7:0] digital_io_output_o,
    input wire logic [7:0] digital_io_output_enable_n_o,
    input wire logic [3:0] interconnect_output_o,
    input wire logic [3:0] interconnect_output_enable_n_o,
    input wire logic system_reset_request_n_o,
    input wire logic fifo_read_clock_source_o,
    input wire logic fifo_write_clock_source_o,
    input wire logic shared_fifo_clock_source_o,
    input wire logic [5:0] in_queue_read_request_o,
    input wire logic [31:0] reg_rdata_o
);
    default clocking cb @(posedge clock_i);
    endclocking
    default disable iff (rst_i);
    chk_reset_state: assert property (disable iff (1'b0) rst_i && $past(rst_i) |->
        digital_io_output_enable_n_o == 8'hFF && interconnect_output_enable_n_o == 4'hF
        && system_reset_request_n_o && in_queue_read_request_o == 6'h00)
        else $error("outputs not at reset values");
    chk_req_onehot: assert property ($onehot0(in_queue_read_request_o))
        else $error("more than one read request");
    chk_req_pulse: assert property (in_queue_read_request_o != 6'h00 |=>
        in_queue_read_request_o == 6'h00) else $error("read request longer than one cycle");
    chk_req_avail: assert property (in_queue_read_request_o != 6'h00 |->
        (in_queue_read_request_o & $past(in_queue_flags_i.word_available)) != 6'h00
        && $past(config_n_i)) else $error("read request without word or during config");
    chk_rdata_idle: assert property (!$past(reg_req_i.rd) |-> reg_rdata_o == 32'h0)
        else $error("read data outside read answer cycle");
    chk_status_ids: assert property ($past(reg_req_i.rd)
        && $past(reg_req_i.addr) == uai_pkg::ADDR_STATUS |->
        reg_rdata_o[11:4] == $past({carrier_identifier_i, slot_identifier_i})
        && reg_rdata_o[0] == !$past(config_n_i)) else $error("status ids or config wrong");
    chk_sysrst_write: assert property ($past(reg_req_i.wr)
        && $past(reg_req_i.addr) == uai_pkg::ADDR_CTRL |->
        system_reset_request_n_o == !$past(reg_req_i.wdata[8])) else $error("reset request wrong");
    chk_dio_write: assert property ($past(reg_req_i.wr)
        && $past(reg_req_i.addr) == uai_pkg::ADDR_DIO |->
        {digital_io_output_enable_n_o, digital_io_output_o} == $past(reg_req_i.wdata[15:0]))
        else $error("digital io outputs wrong");
    chk_umi_write: assert property ($past(reg_req_i.wr)
        && $past(reg_req_i.addr) == uai_pkg::ADDR_UMI |->
        {interconnect_output_enable_n_o, interconnect_output_o} == $past(reg_req_i.wdata[7:0]))
        else $error("interconnect outputs wrong");
    chk_clock_sources: assert property (!$past(rst_i) |->
        fifo_read_clock_source_o != $past(fifo_read_clock_source_o)
        && fifo_write_clock_source_o != $past(fifo_write_clock_source_o)
        && !shared_fifo_clock_source_o) else $error("fifo clock sources wrong");
endmodule // uai_assertions
bind uai_user_application_entity uai_assertions u_uai_assertions (.clock_i, .rst_i, .config_n_i,
    .slot_identifier_i, .carrier_identifier_i, .in_queue_flags_i, .reg_req_i,
    .digital_io_output_o, .digital_io_output_enable_n_o, .interconnect_output_o,
    .interconnect_output_enable_n_o, .system_reset_request_n_o, .fifo_read_clock_source_o,
    .fifo_write_clock_source_o, .shared_fifo_clock_source_o, .in_queue_read_request_o,
    .reg_rdata_o);

// ==== verification/tb_user_app_port_interface.sv ====
`timescale 1ns/1ps
module tb_user_app_port_interface;
    logic clock_i = 1'b0;
    logic rst_i = 1'b1;
    logic ce_i = 1'b1;
    logic config_n_i = 1'b1;
    logic [3:0] slot = 4'h5;
    logic [3:0] carrier = 4'hA;
    logic [7:0] digital_io_input = 8'h00;
    logic [3:0] interconnect_input = 4'h0;
    logic [5:0] avail = 6'h00;
    logic [7:0] latency = 8'h01;
    logic [31:0] word = 32'h0;
    logic [31:0] seed = 32'h7B020DF0;
    logic [31:0] v, e;
    uai_pkg::uai_reg_req_t req = '0;
    uai_pkg::uai_queue_flags_t flags;
    logic [5:0][31:0] qdata;
    logic [5:0] read_req;
    logic [31:0] rdata;
    logic [7:0] digital_io_output, dio_oe_n;
    logic [3:0] interconnect_output, umi_oe_n;
    logic sysrst_n;
    int fails = 0;
    int comparisons = 0;
    always #4 clock_i = ~clock_i;
    uai_user_application_entity u_uai_user_application_entity (.clock_i(clock_i), .ce_i(ce_i),
        .rst_i(rst_i), .config_n_i(config_n_i), .slot_identifier_i(slot),
        .carrier_identifier_i(carrier), .digital_io_input_i(digital_io_input), .digital_io_output_o(digital_io_output),
        .digital_io_output_enable_n_o(dio_oe_n), .interconnect_input_i(interconnect_input),
        .interconnect_output_o(interconnect_output), .interconnect_output_enable_n_o(umi_oe_n),
        .system_reset_request_n_o(sysrst_n), .fifo_read_clock_source_o(),
        .fifo_write_clock_source_o(), .shared_fifo_clock_source_o(), .in_queue_flags_i(flags),
        .in_queue_data_i(qdata), .in_queue_read_request_o(read_req), .reg_req_i(req),
        .reg_rdata_o(rdata));
    uai_queue_model u_uai_queue_model (.clock_i(clock_i), .rst_i(rst_i), .avail_i(avail),
        .latency_i(latency), .word_i(word), .read_request_i(read_req), .flags_o(flags),
        .data_o(qdata));
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock_i);
        req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clock_i);
        req.wr <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clock_i);
        req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
        @(posedge clock_i);
        req.rd <= 1'b0;
        #1 d = rdata;
    endtask
    task automatic wait_ready();
        for (int i = 0; i < 40; i++) begin
            rd(uai_pkg::ADDR_STATUS, v);
            if (v[uai_pkg::ST_READY_BIT] === 1'b1) return;
        end
        check("ready", 32'h1, 32'h0);
    endtask
    task automatic conclude();
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    initial begin
        #100000;
        fails++;
        conclude();
    end
    initial begin
        repeat (4) @(posedge clock_i);
        rst_i <= 1'b0;
        #1 check("oe_n", 32'hF_FF_00, 32'({umi_oe_n, dio_oe_n, digital_io_output}));
        check("sysrst_n", 32'h1, 32'(sysrst_n));
        rd(8'h20, v);
        check("unmapped", 32'h0, v);
        for (int k = 0; k < 4; k++) begin
            seed = lfsr(seed);
            wr(uai_pkg::ADDR_DIO, seed);
            check("dio", 32'(seed[15:0]), 32'({dio_oe_n, digital_io_output}));
            wr(uai_pkg::ADDR_UMI, seed >> 16);
            check("umi", 32'(seed[23:16]), 32'({umi_oe_n, interconnect_output}));
        end
        wr(uai_pkg::ADDR_CTRL, 32'h100);
        check("sysrst_n", 32'h0, 32'(sysrst_n));
        wr(uai_pkg::ADDR_CTRL, 32'h3F);
        check("sysrst_n", 32'h1, 32'(sysrst_n));
        {interconnect_input, digital_io_input, carrier, slot} <= seed[19:0];
        config_n_i <= 1'b0;
        seed = lfsr(seed);
        word <= seed;
        avail <= 6'h3F;
        repeat (30) @(posedge clock_i);
        rd(uai_pkg::ADDR_STATUS, v);
        e = 32'({6'h3F, interconnect_input, digital_io_input, carrier, slot, 4'h1});
        check("status", e, 32'({v[29:4], 1'b0, v[2:0]}));
        config_n_i <= 1'b0 ^ 1'b1;
        for (int k = 0; k < 6; k++) begin
            wait_ready();
            e = seed;
            seed = lfsr(seed);
            word <= seed;
            latency <= (k == 5) ? 8'h1E : ((k % 2) ? 8'h09 : 8'h01);
            if (k == 5) avail <= 6'h08;
            rd(uai_pkg::ADDR_DATA, v);
            check("data", e, v);
            rd(uai_pkg::ADDR_INFO, v);
            check("info", 32'(((k + 1) << 8) | ((k + 1) % 6)), {v[31:8], 5'h0, v[2:0]});
        end
        repeat (60) @(posedge clock_i);
        rd(uai_pkg::ADDR_STATUS, v);
        check("ready", 32'h0, 32'(v[uai_pkg::ST_READY_BIT]));
        rd(uai_pkg::ADDR_INFO, v);
        check("count", 32'h6, 32'(v[31:8]));
        wr(uai_pkg::ADDR_DIO, 32'h00AA);
        rst_i <= 1'b1;
        #1 check("async", 32'hFF00, 32'({dio_oe_n, digital_io_output}));
        repeat (2) @(posedge clock_i);
        rst_i <= 1'b0;
        rd(uai_pkg::ADDR_INFO, v);
        check("count", 32'h0, 32'(v[31:8]));
        conclude();
    end
endmodule // tb_user_app_port_interface
